// File: dv/core_config_registers_monitor.sv
// port assertions for the core configuration registers
`timescale 1ns/1ns
module core_config_registers_monitor (
  input wire logic        clk,        // clock
  input wire logic        rstn,       // reset
  input wire logic        hardResetN, // hard reset
  input wire logic [9:0]  sprNum,     // spr number
  input wire logic        sprWrite,   // write
  input wire logic        sprRead,    // read
  input wire logic [31:0] sprWrData,  // wdata
  input wire logic [31:0] sprRdData,  // rdata
  input wire logic        sprRdAck,   // ack
  input wire logic [3:0]  pllCfg,     // pll pins
  input wire logic        bticLookup, // lookup
  input wire logic        bticHit,    // hit
  input wire logic        brValid,    // predict
  input wire logic        brCrCtr,    // cr/ctr
  input wire logic        brStatic,   // static dir
  input wire logic        predValid,  // pred out
  input wire logic        predTaken,  // pred dir
  input core_config_pkg::clkout_src_t clkSrc // clock src
);
  import core_config_pkg::*;
  logic [31:0] hw_r;
  logic        mapped;

  // shadow of the first register
  always_ff @(posedge clk) begin
    if (!rstn) hw_r <= 32'h0000_0000;
    else if (sprWrite && sprNum == 10'h3F0) hw_r <= sprWrData & 32'hFFFF_FFE7;
  end
  assign mapped = sprNum == 10'h3F0 || sprNum == 10'h3F1 || sprNum == 10'h3F6;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence bticOff;
    !hw_r[5] [*2];
  endsequence
  sequence predReq;
    brValid && (!brCrCtr || !hw_r[2]) && !sprWrite;
  endsequence

  AST_RDACK: assert property (sprRead && mapped |=> sprRdAck)
    else $error("mapped read not acked");
  AST_UNMAP: assert property (sprRead && !mapped |=> !sprRdAck && sprRdData == 0)
    else $error("unmapped read answered");
  AST_HWRD: assert property (sprRead && sprNum == 10'h3F0 |=> sprRdData == $past(hw_r))
    else $error("first register read mismatch");
  AST_PLL: assert property (sprRead && sprNum == 10'h3F1 |=> sprRdData ==
    {$past(pllCfg[0]), $past(pllCfg[1]), $past(pllCfg[2]), $past(pllCfg[3]), 28'h0})
    else $error("pll mirror mismatch");
  AST_CLKRST: assert property (!hardResetN |=> clkSrc == CLK_BUS)
    else $error("clock out not bus in hard reset");
  AST_CLKCORE: assert property (hardResetN && hw_r[25] && !hw_r[13] |=> clkSrc == CLK_CORE)
    else $error("clock out not core");
  AST_CLKRSV: assert property (hardResetN && !hw_r[25] |=> clkSrc == CLK_RESERVED)
    else $error("clock out not reserved");
  AST_BTICOFF: assert property (bticOff ##0 bticLookup |=> !bticHit)
    else $error("hit while target cache off");
  AST_PRED: assert property (predReq |-> ##2 predValid && predTaken == $past(brStatic, 2))
    else $error("static prediction wrong");
endmodule

bind core_config_registers core_config_registers_monitor u_mon (.*);

// File: dv/tb_core_config_registers.sv
// self-checking bench for the core configuration registers
`timescale 1ns/1ns
module tb_core_config_registers;
  import core_config_pkg::*;
  logic        clk, rstn, hardResetN, sprWrite, sprRead, sprRdAck, ctxSync;
  logic        bticAlloc, bticLookup, bticHit, brValid, brCrCtr, brStatic;
  logic        brResolve, brResTaken, predValid, predTaken, dstIssue;
  logic        dstExec, dstCancel, touchIssue, touchExec;
  logic [9:0]  sprNum;
  logic [31:0] sprWrData, sprRdData, mssRoIn;
  logic [3:0]  pllCfg;
  logic [5:0]  bticAllocIdx, bticLookIdx;
  logic [8:0]  brIdx, brResIdx;
  clkout_src_t clkSrc;
  int          num_errors, cmp_count;

  core_config_registers u_dut (.*);

  // clock
  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [9:0] n, input logic [31:0] d);
    @(posedge clk);
    sprWrite <= 1'b1;
    sprNum <= n;
    sprWrData <= d;
    @(posedge clk);
    sprWrite <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [9:0] n, input logic [31:0] e, input logic a);
    @(posedge clk);
    sprRead <= 1'b1;
    sprNum <= n;
    @(posedge clk);
    sprRead <= 1'b0;
    #1;
    chk("rdata", e, sprRdData);
    chk("rack", a, sprRdAck);
  endtask

  task automatic csync;
    @(posedge clk);
    ctxSync <= 1'b1;
    @(posedge clk);
    ctxSync <= 1'b0;
  endtask

  task automatic t_regs;
    rd(10'h3F0, 32'h0000_0000, 1);
    wr(10'h3F0, 32'hFFFF_FFFF);
    csync();
    rd(10'h3F0, 32'hFFFF_FFE7, 1);
    wr(10'h3F1, 32'hFFFF_FFFF);
    csync();
    rd(10'h3F1, 32'hA000_0000, 1);
    rd(10'h3F6, 32'h0000_0002, 1);
    wr(10'h3F6, 32'hFFFF_FFFD);
    rd(10'h3F6, 32'hFFFF_FFFE, 1);
    rd(10'h3FF, 32'h0000_0000, 0);
    wr(10'h3F0, 32'h0000_0000);
  endtask

  task automatic look(input logic [5:0] i, input logic e);
    @(posedge clk);
    bticLookup <= 1'b1;
    bticLookIdx <= i;
    @(posedge clk);
    bticLookup <= 1'b0;
    #1;
    chk("hit", e, bticHit);
  endtask

  task automatic alloc;
    @(posedge clk);
    bticAlloc <= 1'b1;
    @(posedge clk);
    bticAlloc <= 1'b0;
  endtask

  task automatic t_branch_target_cache_enable;
    wr(10'h3F0, 32'h0000_0020);
    alloc();
    look(6'h3F, 1);
    look(6'h00, 0);
    @(posedge clk);
    ctxSync <= 1'b1;
    @(posedge clk);
    ctxSync <= 1'b0;
    look(6'h3F, 0);
    alloc();
    wr(10'h3F0, 32'h0000_0000);
    look(6'h3F, 0);
    alloc();
    look(6'h3F, 0);
  endtask

  task automatic pred(input logic cr, st, e);
    @(posedge clk);
    brValid <= 1'b1;
    brCrCtr <= cr;
    brStatic <= st;
    @(posedge clk);
    brValid <= 1'b0;
    @(posedge clk);
    #1;
    chk("pvalid", 1, predValid);
    chk("ptaken", e, predTaken);
  endtask

  task automatic t_pred;
    pred(1, 1, 1);
    wr(10'h3F0, 32'h0000_0004);
    pred(1, 1, 0);
    pred(0, 1, 1);
    @(posedge clk);
    brResolve <= 1'b1;
    @(posedge clk);
    brResolve <= 1'b0;
    pred(1, 0, 1);
  endtask

  task automatic issue(input logic e);
    @(posedge clk);
    dstIssue <= 1'b1;
    touchIssue <= 1'b1;
    @(posedge clk);
    dstIssue <= 1'b0;
    touchIssue <= 1'b0;
    #1;
    chk("dst", e, dstExec);
    chk("touch", e, touchExec);
  endtask

  task automatic t_touch;
    issue(1);
    wr(10'h3F0, 32'h0000_0003);
    chk("cancel", 1, dstCancel);
    issue(0);
    wr(10'h3F0, 32'h0000_0000);
  endtask

  task automatic t_clk;
    clkout_src_t exp [4] = '{CLK_RESERVED, CLK_RESERVED, CLK_CORE, CLK_BUS};
    for (int k = 0; k < 4; k++) begin
      wr(10'h3F0, {6'h00, k[1], 11'h000, k[0], 13'h0000});
      @(posedge clk);
      #1;
      chk("clksrc", 32'(exp[k]), 32'(clkSrc));
    end
    wr(10'h3F0, 32'h0200_0000);
    @(posedge clk);
    hardResetN <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("clkhard", 32'(CLK_BUS), 32'(clkSrc));
  endtask

  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // stimulus and reset
  initial begin
    {clk, rstn, sprWrite, sprRead, ctxSync, bticAlloc, bticLookup} = '0;
    {brValid, brCrCtr, brStatic, brResolve, dstIssue, touchIssue} = '0;
    {sprNum, sprWrData, bticLookIdx} = '0;
    hardResetN = 1'b1;
    brResTaken = 1'b1;
    bticAllocIdx = 6'h3F;
    brIdx = 9'h1FF;
    brResIdx = 9'h1FF;
    pllCfg = 4'h5;
    mssRoIn = 32'h0000_0002;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_branch_target_cache_enable();
    t_pred();
    t_touch();
    t_clk();
    test_done();
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule

// File: hw/bht_table.sv
// 512-entry two-bit branch history counters with registered read
`timescale 1ns/1ns
`include "core_config_defs.svh"
module bht_table (
  input  wire logic       clk,      // core clock
  input  wire logic       rstn,     // power-on reset, active low
  input  wire logic [8:0] rdIdx,    // lookup index
  output logic      [1:0] rdData,   // counter, one cycle after lookup
  input  wire logic       upEn,     // resolve update strobe
  input  wire logic [8:0] upIdx,    // entry to update
  input  wire logic       upTaken   // resolved direction
);
  import core_config_pkg::*;

  bht_state_t st_r;
  bht_state_t st_nxt;
  logic [1:0] cur;

  // saturating counter update, read returns old value on collision
  always_comb begin
    st_nxt = st_r;
    cur = st_r.cnt[upIdx];
    st_nxt.rdData = st_r.cnt[rdIdx];
    if (upEn) begin
      if (upTaken && cur != `BHT_STRONG_TAKEN) begin
        st_nxt.cnt[upIdx] = cur + 2'h1;
      end else if (!upTaken && cur != `BHT_STRONG_NOT) begin
        st_nxt.cnt[upIdx] = cur - 2'h1;
      end
    end
  end

  // every entry starts weakly not-taken
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r.cnt    <= {512{`BHT_WEAK_NOT_TAKEN}}; // RULE5
      st_r.rdData <= `BHT_WEAK_NOT_TAKEN;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rdData;

endmodule

// File: hw/core_config_defs.svh
// constants for the core configuration register bank
// Function
// RULE1: branch target cache enable low invalidates all 64 entries, blocks new allocations.
// RULE2: every context synchronization flushes the branch target cache.
// RULE3: history enable low predicts CR/CTR conditional branches statically.
// RULE4: history enable high predicts from the 512-entry dynamic history table.
// RULE5: power-on reset clears history enable, sets all entries weakly not-taken.
// RULE6: stream-touch no-op high no-ops stream touches and cancels running streams.
// RULE7: cache-touch no-op high no-ops cache block touches; low executes them.
// RULE8: clock out is bus clock in hard reset; select 1/0 core, 1/1 bus.
// RULE9: first configuration register read and written at special register 1008.
// RULE10: software follows each write to it with a context synchronization.
// RULE11: second register bits 0..3 mirror PLL pins, read-only; rest reserved.
// RULE12: second configuration register readable at special register 1009.
// RULE13: software puts memory sync and context sync after second register writes.
// RULE14: memory subsystem control register sits at special register 1014.
// RULE15: reset zeroes its writable bits; read-only bits keep external values.
// RULE16: first register reserved bits 27 and 28 ignore writes, read zero.
`ifndef CORE_CONFIG_DEFS_SVH
`define CORE_CONFIG_DEFS_SVH

// special register numbers
`define SPR_CORE_HW_CONFIG    10'h3F0
`define SPR_PLL_CONFIG_MIRROR 10'h3F1
`define SPR_MEM_SUBSYS_CTRL   10'h3F6

// field positions, lsb-based (big-endian bit n sits at 31-n)
`define HW_BRANCH_TARGET_CACHE_ENABLE_EN_BIT    5
`define HW_BHT_EN_BIT     2
`define HW_DST_NOOP_BIT   1
`define HW_TOUCH_NOOP_BIT 0
`define HW_CLKSEL_HI_BIT  25
`define HW_CLKSEL_LO_BIT  13

// writable bits; reserved 27 and 28 masked out
`define HW_WRITE_MASK     32'hFFFF_FFE7
`define HW_RESET          32'h0000_0000

// pll mirror field sits in big-endian bits 0..3
`define PLL_FIELD_LSB     28

// memory subsystem control
`define MSS_RO_MASK       32'h0000_0003
`define MSS_RESET         32'h0000_0000

// branch history counter encodings
`define BHT_WEAK_NOT_TAKEN 2'h1
`define BHT_STRONG_TAKEN   2'h3
`define BHT_STRONG_NOT     2'h0

`endif

// File: hw/core_config_pkg.sv
// types for the core configuration register bank
package core_config_pkg;

  typedef enum logic [1:0] {
    CLK_BUS,
    CLK_CORE,
    CLK_RESERVED
  } clkout_src_t;

  typedef struct packed {
    logic [31:0] hwCfg;
    logic [31:0] mssCtl;
    logic [63:0] bticValid;
    logic [31:0] rdData;
    logic        rdAck;
    logic        bticHit;
    logic        pendValid;
    logic        pendStatic;
    logic        pendUseTable;
    logic        predValid;
    logic        predTaken;
    logic        dstExec;
    logic        dstCancel;
    logic        touchExec;
    clkout_src_t clkSrc;
  } cfg_state_t;

  typedef struct packed {
    logic [511:0][1:0] cnt;
    logic [1:0]        rdData;
  } bht_state_t;

endpackage

// File: hw/core_config_registers.sv
// core configuration registers and the branch/touch controls they steer
`timescale 1ns/1ns
`include "core_config_defs.svh"
module core_config_registers (
  input  wire logic        clk,          // core clock, 10 MHz
  input  wire logic        rstn,         // power-on reset, active low
  input  wire logic        hardResetN,   // hard reset pin, active low
  // special register moves
  input  wire logic [9:0]  sprNum,       // special register number
  input  wire logic        sprWrite,     // move-to strobe
  input  wire logic        sprRead,      // move-from strobe
  input  wire logic [31:0] sprWrData,    // move-to data
  output logic      [31:0] sprRdData,    // move-from data
  output logic             sprRdAck,     // read hit a mapped register
  // external levels
  input  wire logic [3:0]  pllCfg,       // pll pins, [0] is bit 0
  input  wire logic [31:0] mssRoIn,      // external read-only mss bits
  input  wire logic        ctxSync,      // context synchronization
  // branch target cache
  input  wire logic        bticAlloc,    // allocate request
  input  wire logic [5:0]  bticAllocIdx, // entry to allocate
  input  wire logic        bticLookup,   // lookup strobe
  input  wire logic [5:0]  bticLookIdx,  // entry to look up
  output logic             bticHit,      // lookup hit, one cycle later
  // branch prediction
  input  wire logic        brValid,      // conditional branch to predict
  input  wire logic [8:0]  brIdx,        // history index
  input  wire logic        brCrCtr,      // branch uses CR or CTR
  input  wire logic        brStatic,     // static prediction taken
  input  wire logic        brResolve,    // branch resolved strobe
  input  wire logic [8:0]  brResIdx,     // resolved history index
  input  wire logic        brResTaken,   // resolved direction
  output logic             predValid,    // prediction ready, 2 cycles
  output logic             predTaken,    // predicted direction
  // touch instructions
  input  wire logic        dstIssue,     // stream touch issued
  output logic             dstExec,      // stream touch performed
  output logic             dstCancel,    // cancel all running streams
  input  wire logic        touchIssue,   // cache block touch issued
  output logic             touchExec,    // cache block touch performed
  // clock out
  output core_config_pkg::clkout_src_t clkSrc // clock out source
);
  import core_config_pkg::*;

  // block state, apart from the history counters in u_bht, in one packed register
  cfg_state_t st_r;
  cfg_state_t st_nxt;
  logic [1:0] bhtRd;
  logic       wrHw;
  logic       wrMss;
  logic [31:0] hwNew;
  logic [31:0] pllWord;
  logic [31:0] mssView;
  logic       bticEn;
  logic       bhtEn;

  // history counters
  // updates only train while the table is enabled
  // reads run every cycle so the lookup stays two deep
  bht_table u_bht (
    .clk     (clk),
    .rstn    (rstn),
    .rdIdx   (brIdx),
    .rdData  (bhtRd),
    .upEn    (brResolve && bhtEn), // RULE4
    .upIdx   (brResIdx),
    .upTaken (brResTaken)
  );

  // decode and visible register values
  // reserved bits are masked on the way in, so they read
  // back zero without a second gate on the read path
  assign wrHw  = sprWrite && sprNum == `SPR_CORE_HW_CONFIG; // RULE9
  assign wrMss = sprWrite && sprNum == `SPR_MEM_SUBSYS_CTRL; // RULE14
  assign hwNew = sprWrData & `HW_WRITE_MASK; // RULE16
  assign bticEn = st_r.hwCfg[`HW_BRANCH_TARGET_CACHE_ENABLE_EN_BIT];
  assign bhtEn  = st_r.hwCfg[`HW_BHT_EN_BIT];
  assign pllWord = {pllCfg[0], pllCfg[1], pllCfg[2], pllCfg[3],
                    28'h000_0000}; // RULE11
  assign mssView = (st_r.mssCtl & ~`MSS_RO_MASK)
                 | (mssRoIn & `MSS_RO_MASK); // RULE15

  // next-state logic
  // every field defaults to holding; pulses below are
  // recomputed each cycle so they last one cycle
  always_comb begin
    st_nxt = st_r;

    // register writes; the pll mirror ignores moves to it
    // the mss read-only bits are dropped here so only the
    // external levels show through on a read
    if (wrHw) begin
      st_nxt.hwCfg = hwNew; // RULE9
    end
    if (wrMss) begin
      st_nxt.mssCtl = sprWrData & ~`MSS_RO_MASK;
    end

    // register reads, unmapped numbers read zero without ack
    // read data is zero outside the answer cycle, so a
    // careless sampler never picks up stale contents
    st_nxt.rdAck  = 1'b0;
    st_nxt.rdData = 32'h0000_0000;
    if (sprRead) begin
      unique case (sprNum)
        `SPR_CORE_HW_CONFIG: begin
          st_nxt.rdAck  = 1'b1;
          st_nxt.rdData = st_r.hwCfg; // RULE9
        end
        `SPR_PLL_CONFIG_MIRROR: begin
          st_nxt.rdAck  = 1'b1;
          st_nxt.rdData = pllWord; // RULE12
        end
        `SPR_MEM_SUBSYS_CTRL: begin
          st_nxt.rdAck  = 1'b1;
          st_nxt.rdData = mssView; // RULE14
        end
        default: begin
          st_nxt.rdAck  = 1'b0;
        end
      endcase
    end

    // branch target cache valid bits
    // the flush terms come last so a clear beats an
    // allocation in the same cycle; a disabled cache
    // keeps clearing for as long as the bit stays low
    if (bticAlloc && bticEn) begin
      st_nxt.bticValid[bticAllocIdx] = 1'b1; // RULE1
    end
    if (!bticEn) begin
      st_nxt.bticValid = 64'h0000_0000_0000_0000; // RULE1
    end
    if (ctxSync) begin
      st_nxt.bticValid = 64'h0000_0000_0000_0000; // RULE2
    end
    st_nxt.bticHit = bticLookup && bticEn
                   && st_r.bticValid[bticLookIdx]; // RULE1

    // prediction stage one waits for the table read
    // the table read issued this cycle returns next cycle,
    // so the request flags wait one stage alongside it
    st_nxt.pendValid    = brValid;
    st_nxt.pendStatic   = brStatic;
    st_nxt.pendUseTable = brCrCtr && bhtEn; // RULE3

    // prediction stage two picks table or static
    // only condition or count branches may use the table;
    // everything else keeps its static direction
    st_nxt.predValid = st_r.pendValid;
    if (st_r.pendUseTable) begin
      st_nxt.predTaken = bhtRd[1]; // RULE4
    end else begin
      st_nxt.predTaken = st_r.pendStatic; // RULE3
    end

    // touch instructions
    // a no-op bit set blocks the execute pulse; the cancel
    // fires once, on the write that turns stream no-op on,
    // which stops streams started before it
    st_nxt.dstExec = dstIssue && !st_r.hwCfg[`HW_DST_NOOP_BIT]; // RULE6
    st_nxt.dstCancel = wrHw && hwNew[`HW_DST_NOOP_BIT]
                     && !st_r.hwCfg[`HW_DST_NOOP_BIT]; // RULE6
    st_nxt.touchExec = touchIssue
                     && !st_r.hwCfg[`HW_TOUCH_NOOP_BIT]; // RULE7

    // clock out source
    // hard reset forces the bus clock regardless of the
    // select bits; the reserved codes are reported as such
    if (!hardResetN) begin
      st_nxt.clkSrc = CLK_BUS; // RULE8
    end else begin
      unique case ({st_r.hwCfg[`HW_CLKSEL_HI_BIT],
                    st_r.hwCfg[`HW_CLKSEL_LO_BIT]})
        2'b10:   st_nxt.clkSrc = CLK_CORE; // RULE8
        2'b11:   st_nxt.clkSrc = CLK_BUS; // RULE8
        default: st_nxt.clkSrc = CLK_RESERVED; // RULE8
      endcase
    end
  end

  // state register
  // sync reset; the branch cache starts empty and
  // history use starts disabled
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r.hwCfg        <= `HW_RESET; // RULE5
      st_r.mssCtl       <= `MSS_RESET; // RULE15
      st_r.bticValid    <= 64'h0000_0000_0000_0000;
      st_r.rdData       <= 32'h0000_0000;
      st_r.rdAck        <= 1'b0;
      st_r.bticHit      <= 1'b0;
      st_r.pendValid    <= 1'b0;
      st_r.pendStatic   <= 1'b0;
      st_r.pendUseTable <= 1'b0;
      st_r.predValid    <= 1'b0;
      st_r.predTaken    <= 1'b0;
      st_r.dstExec      <= 1'b0;
      st_r.dstCancel    <= 1'b0;
      st_r.touchExec    <= 1'b0;
      st_r.clkSrc       <= CLK_BUS;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  // no logic between the flops and the pins keeps every
  // output glitch free
  assign sprRdData = st_r.rdData;
  assign sprRdAck  = st_r.rdAck;
  assign bticHit   = st_r.bticHit;
  assign predValid = st_r.predValid;
  assign predTaken = st_r.predTaken;
  assign dstExec   = st_r.dstExec;
  assign dstCancel = st_r.dstCancel;
  assign touchExec = st_r.touchExec;
  assign clkSrc    = st_r.clkSrc;

endmodule
